// [rtl/iduc_consts.svh]
// Constants for the interpolating oscillator up-converter.
`ifndef IDUC_CONSTS_SVH
`define IDUC_CONSTS_SVH

`define IDUC_W          16
`define IDUC_NSTG       4
`define IDUC_FIFO_DEPTH 4
`define IDUC_ACC_W      32
`define IDUC_LUT_AW     6
`define IDUC_LUT_MSB    31
`define IDUC_LUT_LSB    26
`define IDUC_COS_OFS    6'h10
`define IDUC_QTR        5'h10
`define IDUC_FULL       16'sh7FFF
`define IDUC_ACC_RST    32'h0
`define IDUC_CNT_RST    4'h0
`define IDUC_CNT_ONE    4'h1
`define IDUC_MASK_16X   4'hF
`define IDUC_MASK_8X    4'h7
`define IDUC_MASK_STG0  4'h7
`define IDUC_CNT_TOP    3
`define IDUC_HB_C       21'sh9
`define IDUC_HB_SH      4
`define IDUC_MIX_SH     15
`define IDUC_SAT_MAX    33'sh7FFF
`define IDUC_SAT_MIN    -33'sh8000

`endif

// [rtl/iduc_pkg.sv]
// Types shared by the up-converter modules.
package iduc_pkg;

    // One complex sample.
    typedef struct packed {
        logic signed [15:0] i;
        logic signed [15:0] q;
    } iduc_smp_s;

    // One half-band stage: four-sample history and the emitted sample.
    typedef struct packed {
        iduc_smp_s h0;
        iduc_smp_s h1;
        iduc_smp_s h2;
        iduc_smp_s h3;
        iduc_smp_s y;
    } iduc_stg_s;

    typedef enum logic [1:0] {
        IDUC_CLK_PLL  = 2'b00,
        IDUC_CLK_EXT  = 2'b01,
        IDUC_CLK_DUAL = 2'b11
    } iduc_clkmode_e;

    typedef enum logic [1:0] {
        IDUC_MIX_BYP  = 2'b00,
        IDUC_MIX_REAL = 2'b01,
        IDUC_MIX_CPLX = 2'b11
    } iduc_mixmode_e;

endpackage : iduc_pkg

// [rtl/iduc_fifo.sv]
// Small input sample FIFO with valid and ready on both sides.
`timescale 1ns/1ps
`include "iduc_consts.svh"

module iduc_fifo #(
    parameter int W     = 32,
    parameter int DEPTH = `IDUC_FIFO_DEPTH
) (
    // Clock and reset.
    input  wire logic         mclk,
    input  wire logic         reset_n,
    // Filling side.
    input  wire logic         inValid,
    input  wire logic [W-1:0] inData,
    output logic              inReady,
    // Draining side.
    output logic              outValid,
    output logic [W-1:0]      outData,
    input  wire logic         outReady
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0]           wp;
        logic [AW-1:0]           rp;
        logic [AW:0]             cnt;
        logic                    rdy;
    } iduc_ff_s;

    iduc_ff_s s_q;
    iduc_ff_s s_d;
    logic     push;
    logic     pop;

    function automatic logic [AW-1:0] nextPtr(input logic [AW-1:0] p);
        nextPtr = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
    endfunction : nextPtr

    assign inReady  = s_q.rdy;
    assign outValid = (s_q.cnt != '0);
    assign outData  = s_q.mem[s_q.rp];

    always_comb begin
        s_d  = s_q;
        push = inValid & s_q.rdy;
        pop  = outReady & (s_q.cnt != '0);
        if (push) begin
            s_d.mem[s_q.wp] = inData;
            s_d.wp          = nextPtr(s_q.wp);
        end
        if (pop) begin
            s_d.rp = nextPtr(s_q.rp);
        end
        s_d.cnt = (AW+1)'(s_q.cnt + push - pop);
        // Ready is registered so the source sees a clean flop.
        s_d.rdy = (s_d.cnt < (AW+1)'(DEPTH));
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

endmodule : iduc_fifo

// [rtl/iduc_sine_rom.sv]
// Quarter-wave sine table with two registered read ports.
`timescale 1ns/1ps
`include "iduc_consts.svh"

module iduc_sine_rom (
    // Clock and reset.
    input  wire logic                     mclk,
    input  wire logic                     reset_n,
    // Phase addresses.
    input  wire logic [`IDUC_LUT_AW-1:0]  addrA,
    input  wire logic [`IDUC_LUT_AW-1:0]  addrB,
    // Registered sine values.
    output logic signed [`IDUC_W-1:0]     dataA,
    output logic signed [`IDUC_W-1:0]     dataB
);
    typedef struct packed {
        logic signed [`IDUC_W-1:0] a;
        logic signed [`IDUC_W-1:0] b;
    } iduc_rom_s;

    iduc_rom_s s_q;
    iduc_rom_s s_d;

    function automatic logic signed [15:0] qtab(input logic [3:0] k);
        case (k)
            4'h0: qtab = 16'sh0000;
            4'h1: qtab = 16'sh0C8C;
            4'h2: qtab = 16'sh18F9;
            4'h3: qtab = 16'sh2528;
            4'h4: qtab = 16'sh30FB;
            4'h5: qtab = 16'sh3C56;
            4'h6: qtab = 16'sh471C;
            4'h7: qtab = 16'sh5133;
            4'h8: qtab = 16'sh5A82;
            4'h9: qtab = 16'sh62F1;
            4'hA: qtab = 16'sh6A6D;
            4'hB: qtab = 16'sh70E2;
            4'hC: qtab = 16'sh7641;
            4'hD: qtab = 16'sh7A7C;
            4'hE: qtab = 16'sh7D89;
            default: qtab = 16'sh7F61;
        endcase
    endfunction : qtab

    // Odd quadrants read the table mirrored, the upper half is negated.
    function automatic logic signed [15:0] sine(input logic [5:0] a);
        logic [4:0]         idx;
        logic signed [15:0] mag;
        idx  = a[4] ? 5'(`IDUC_QTR - {1'b0, a[3:0]}) : {1'b0, a[3:0]};
        mag  = (idx == `IDUC_QTR) ? `IDUC_FULL : qtab(idx[3:0]);
        sine = a[5] ? 16'(-mag) : mag;
    endfunction : sine

    assign dataA = s_q.a;
    assign dataB = s_q.b;

    always_comb begin
        s_d.a = sine(addrA);
        s_d.b = sine(addrB);
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

endmodule : iduc_sine_rom

// [rtl/iduc_top.sv]
// Interpolating half-band chain, oscillator and mixer of the converter front end.
`timescale 1ns/1ps
`include "iduc_consts.svh"

module iduc_top (
    // Clock and reset.
    input  wire logic                   mclk,
    input  wire logic                   reset_n,
    // Configuration.
    input  wire iduc_pkg::iduc_clkmode_e clkMode,
    input  wire logic                   ratio16,
    input  wire iduc_pkg::iduc_mixmode_e mixMode,
    input  wire logic [`IDUC_ACC_W-1:0] tuneWord,
    // Data-rate reference from the partner, sampled on mclk.
    input  wire logic                   refClk,
    // Input sample stream.
    input  wire logic                   inValid,
    input  wire iduc_pkg::iduc_smp_s    inSmp,
    output logic                        inReady,
    // Converter-rate output.
    output logic signed [`IDUC_W-1:0]   outReal,
    output logic signed [`IDUC_W-1:0]   outImag,
    output logic                        outValid,
    output logic                        underrun
);
    import iduc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // State.

    typedef struct packed {
        logic [3:0]                  cnt;
        logic                        refQ;
        iduc_stg_s [`IDUC_NSTG-1:0]  stg;
        logic [`IDUC_ACC_W-1:0]      acc;
        logic signed [`IDUC_W-1:0]   re;
        logic signed [`IDUC_W-1:0]   im;
        logic                        vld;
        logic                        undr;
    } iduc_top_s;

    iduc_top_s s_q;
    iduc_top_s s_d;

    logic                     dataStb;
    logic                     refRise;
    logic                     fifoValid;
    iduc_smp_s                fifoData;
    iduc_smp_s                src;
    logic signed [`IDUC_W-1:0] cosV;
    logic signed [`IDUC_W-1:0] sinV;
    logic [`IDUC_LUT_AW-1:0]  sinAddr;
    logic [`IDUC_LUT_AW-1:0]  cosAddr;

    ////////////////////////////////////////////////////////////////////////////
    // Arithmetic helpers.

    function automatic logic signed [15:0] sat16(input logic signed [32:0] v);
        if (v > `IDUC_SAT_MAX) begin
            sat16 = 16'sh7FFF;
        end else if (v < `IDUC_SAT_MIN) begin
            sat16 = 16'sh8000;
        end else begin
            sat16 = v[15:0];
        end
    endfunction : sat16

    // Four-tap form of the half-band: -1 0 9 16 9 0 -1, over 16.
    function automatic logic signed [15:0] hb(
        input logic signed [15:0] a,
        input logic signed [15:0] b,
        input logic signed [15:0] c,
        input logic signed [15:0] d
    );
        logic signed [20:0] s;
        s  = 21'(a) + 21'(b);
        s  = s * `IDUC_HB_C;
        s  = s - 21'(c) - 21'(d);
        s  = s >>> `IDUC_HB_SH;
        hb = sat16(33'(s));
    endfunction : hb

    function automatic iduc_smp_s hbSmp(
        input iduc_smp_s a,
        input iduc_smp_s b,
        input iduc_smp_s c,
        input iduc_smp_s d
    );
        hbSmp.i = hb(a.i, b.i, c.i, d.i);
        hbSmp.q = hb(a.q, b.q, c.q, d.q);
    endfunction : hbSmp

    function automatic logic signed [15:0] mac2(
        input logic signed [15:0] x0,
        input logic signed [15:0] w0,
        input logic signed [15:0] x1,
        input logic signed [15:0] w1,
        input logic               sub
    );
        logic signed [32:0] p0;
        logic signed [32:0] p1;
        logic signed [32:0] s;
        p0   = 33'(x0) * 33'(w0);
        p1   = 33'(x1) * 33'(w1);
        s    = sub ? (p0 - p1) : (p0 + p1);
        mac2 = sat16(s >>> `IDUC_MIX_SH);
    endfunction : mac2

    // Stage k emits every (mask+1) clocks; the last stage emits every clock.
    function automatic logic [3:0] stgMask(input int k);
        stgMask = `IDUC_MASK_STG0 >> k;
    endfunction : stgMask

    ////////////////////////////////////////////////////////////////////////////
    // Input buffer, drained once per data-rate slot.

    iduc_fifo #(
        .W     ($bits(iduc_smp_s)),
        .DEPTH (`IDUC_FIFO_DEPTH)
    ) u_fifo (
        .mclk     (mclk),
        .reset_n  (reset_n),
        .inValid  (inValid),
        .inData   (inSmp),
        .inReady  (inReady),
        .outValid (fifoValid),
        .outData  (fifoData),
        .outReady (dataStb)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Oscillator wave table.

    assign sinAddr = s_q.acc[`IDUC_LUT_MSB:`IDUC_LUT_LSB];
    assign cosAddr = 6'(sinAddr + `IDUC_COS_OFS);

    iduc_sine_rom u_rom (
        .mclk    (mclk),
        .reset_n (reset_n),
        .addrA   (sinAddr),
        .addrB   (cosAddr),
        .dataA   (sinV),
        .dataB   (cosV)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic.

    always_comb begin
        s_d      = s_q;
        s_d.refQ = refClk;
        // The reference is taken as synchronous, so one flop suffices for edges.
        refRise  = refClk & ~s_q.refQ;

        dataStb = ((s_q.cnt & (ratio16 ? `IDUC_MASK_16X : `IDUC_MASK_8X)) == '0);

        // In reference modes the divider is realigned on every rising reference edge outside a data slot.
        // A reference faster than mclk/ratio would add data slots.
        // An edge that lands on a slot is not realigned, so no slot is ever doubled.
        if ((clkMode != IDUC_CLK_EXT) && refRise && !dataStb) begin
            s_d.cnt = `IDUC_CNT_RST;
        end else begin
            s_d.cnt = 4'(s_q.cnt + `IDUC_CNT_ONE);
        end
        src      = fifoValid ? fifoData : '0;
        s_d.undr = dataStb & ~fifoValid;

        // 16x uses all stages, 8x bypasses the first.
        for (int k = 0; k < `IDUC_NSTG; k++) begin
            if ((k >= (ratio16 ? 0 : 1)) && ((s_q.cnt & stgMask(k)) == '0)) begin
                if (!s_q.cnt[`IDUC_CNT_TOP-k]) begin
                    // Original slot: shift in and pass the centre sample untouched.
                    s_d.stg[k].h0 = (k == (ratio16 ? 0 : 1)) ? src
                                  : s_q.stg[(k == 0) ? 0 : k - 1].y;
                    s_d.stg[k].h1 = s_q.stg[k].h0;
                    s_d.stg[k].h2 = s_q.stg[k].h1;
                    s_d.stg[k].h3 = s_q.stg[k].h2;
                    s_d.stg[k].y  = s_q.stg[k].h1;
                end else begin
                    // Stuffed zero slot: zero taps drop out, leaving four products.
                    s_d.stg[k].y = hbSmp(s_q.stg[k].h1, s_q.stg[k].h2,
                                         s_q.stg[k].h0, s_q.stg[k].h3);
                end
            end
        end

        s_d.acc = `IDUC_ACC_W'(s_q.acc + tuneWord);

        case (mixMode)
            IDUC_MIX_BYP: begin
                s_d.re = s_q.stg[`IDUC_NSTG-1].y.i;
                s_d.im = s_q.stg[`IDUC_NSTG-1].y.q;
            end
            IDUC_MIX_REAL: begin
                s_d.re = mac2(s_q.stg[`IDUC_NSTG-1].y.i, cosV,
                              s_q.stg[`IDUC_NSTG-1].y.q, sinV, 1'b1);
                s_d.im = '0;
            end
            default: begin
                s_d.re = mac2(s_q.stg[`IDUC_NSTG-1].y.i, cosV,
                              s_q.stg[`IDUC_NSTG-1].y.q, sinV, 1'b1);
                s_d.im = mac2(s_q.stg[`IDUC_NSTG-1].y.i, sinV,
                              s_q.stg[`IDUC_NSTG-1].y.q, cosV, 1'b0);
            end
        endcase

        s_d.vld = s_q.vld | (dataStb & fifoValid);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers.

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            s_q     <= '0;
            s_q.cnt <= `IDUC_CNT_RST;
            s_q.acc <= `IDUC_ACC_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign outReal  = s_q.re;
    assign outImag  = s_q.im;
    assign outValid = s_q.vld;
    assign underrun = s_q.undr;

endmodule : iduc_top

// [dv/iduc_checker.sv]
// Port checker for the up-converter.
`timescale 1ns/1ps
module iduc_checker (
    // Clock and reset.
    input wire logic                    mclk,
    input wire logic                    reset_n,
    // Configuration.
    input wire iduc_pkg::iduc_clkmode_e clkMode,
    input wire logic                    ratio16,
    input wire iduc_pkg::iduc_mixmode_e mixMode,
    // Streams.
    input wire logic                    refClk,
    input wire logic                    inValid,
    input wire logic                    inReady,
    input wire logic signed [15:0]      outImag,
    input wire logic                    outValid,
    input wire logic                    underrun
);
    import iduc_pkg::*;
    logic [4:0] gap_q;
    logic [6:0] idle_q;
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    // Saturating counts since the last underrun and since the last accepted word.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            gap_q  <= 5'h1F;
            idle_q <= 7'h00;
        end else begin
            gap_q  <= underrun ? 5'h01 : gap_q + {4'h0, gap_q != 5'h1F};
            idle_q <= (inValid && inReady) ? 7'h00 : idle_q + {6'h00, idle_q != 7'h7F};
        end
    end
    ready_after_reset_a: assert property ($rose(reset_n) |-> ##[0:2] inReady)
        else $error("inReady did not rise after reset");
    ready_drop_a: assert property ($fell(inReady) |-> $past(inValid))
        else $error("inReady fell without a push");
    full_no_under_a: assert property (!inReady |-> !underrun)
        else $error("underrun while the buffer was full");
    under_pulse_a: assert property (underrun |=> !underrun)
        else $error("underrun longer than one cycle");
    slot_gap_a: assert property (underrun && clkMode == IDUC_CLK_EXT |->
        gap_q >= (ratio16 ? 5'h10 : 5'h08)) else $error("data slots too close");
    ref_slot_a: assert property ($rose(refClk) && clkMode != IDUC_CLK_EXT &&
        idle_q > 7'h60 |-> ##[1:3] underrun) else $error("reference edge made no slot");
    valid_hold_a: assert property (outValid |=> outValid)
        else $error("outValid dropped");
    real_imag_a: assert property ((mixMode == IDUC_MIX_REAL) [*2] |-> outImag == '0)
        else $error("imaginary output not zero in real mode");
endmodule : iduc_checker

// [dv/iduc_partner.sv]
// Baseband source model feeding samples and the data-rate reference.
`timescale 1ns/1ps
module iduc_partner (
    // Clock, reset and set-up.
    input wire logic                mclk,
    input wire logic                reset_n,
    input wire logic                ratio16,
    input wire logic                refOn,
    input wire logic                stream,
    input wire logic                shot,
    input wire logic                hold,
    input wire iduc_pkg::iduc_smp_s value,
    // Towards the converter.
    output logic                    refClk,
    output logic                    inValid,
    output iduc_pkg::iduc_smp_s     inSmp,
    input wire logic                inReady
);
    import iduc_pkg::*;
    logic [3:0] phase;
    logic       left;
    logic       taken;
    logic       stall;
    initial begin
        refClk  = 1'b0;
        inValid = 1'b0;
        inSmp   = '0;
    end
    // A word stands until taken; idle data toggles so a stale value never looks valid.
    always @(posedge mclk) begin
        taken = inValid && inReady;
        stall = hold;
        #1;
        if (!reset_n) begin
            phase   = 4'h0;
            left    = shot;
            refClk  = 1'b0;
            inValid = 1'b0;
        end else begin
            phase  = phase + 4'h1;
            // Low half first, so the first rising edge after reset is a true period start.
            refClk = refOn && (phase & (ratio16 ? 4'hF : 4'h7)) >= (ratio16 ? 4'h8 : 4'h4);
            if (taken) left = 1'b0;
            if (taken || !inValid) begin
                inValid = (stream || left) && !stall;
                inSmp   = inValid ? value : ~inSmp;
            end
        end
    end
endmodule : iduc_partner

// [dv/testbench.sv]
// Self-checking bench for the interpolating up-converter.
`timescale 1ns/1ps
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin bad_count++; \
    $display("unexpected %s exp %0d got %0d", n, e, s); end end
module testbench;
    import iduc_pkg::*;
    logic               mclk = 1'b0;
    logic               reset_n = 1'b0;
    iduc_clkmode_e      clkMode = IDUC_CLK_EXT;
    logic               ratio16 = 1'b1;
    iduc_mixmode_e      mixMode = IDUC_MIX_BYP;
    logic [31:0]        tuneWord = 32'h0;
    logic               stream = 1'b0, shot = 1'b0, hold = 1'b0;
    logic               refClk, inValid, inReady, outValid, underrun;
    iduc_smp_s          value = '0, inSmp;
    logic signed [15:0] outReal, outImag;
    logic signed [15:0] rec [2][128];
    int                 bad_count = 0, checked = 0, cycles = 0, seed = 60069;
    int                 mdl [$];
    iduc_clkmode_e      cms [3] = '{IDUC_CLK_EXT, IDUC_CLK_PLL, IDUC_CLK_DUAL};
    always #12.5 mclk = ~mclk;
    always @(posedge mclk) #1 hold = ($random(seed) % 4) == 0;
    iduc_top u_dut (.mclk(mclk), .reset_n(reset_n), .clkMode(clkMode), .ratio16(ratio16),
        .mixMode(mixMode), .tuneWord(tuneWord), .refClk(refClk), .inValid(inValid),
        .inSmp(inSmp), .inReady(inReady), .outReal(outReal), .outImag(outImag),
        .outValid(outValid), .underrun(underrun));
    iduc_partner u_src (.mclk(mclk), .reset_n(reset_n), .ratio16(ratio16),
        .refOn(clkMode != IDUC_CLK_EXT), .stream(stream), .shot(shot), .hold(hold),
        .value(value), .refClk(refClk), .inValid(inValid), .inSmp(inSmp), .inReady(inReady));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic results();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : results
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 10000) begin
            bad_count++;
            results();
        end
    end
    task automatic start(iduc_clkmode_e cm, logic r, iduc_mixmode_e mm, logic [31:0] tw,
                         logic st, logic sh, iduc_smp_s v);
        @(posedge mclk);
        #1;
        reset_n  = 1'b0;
        clkMode  = cm;
        ratio16  = r;
        mixMode  = mm;
        tuneWord = tw;
        {stream, shot, value} = {st, sh, v};
        repeat (3) @(posedge mclk);
        #1;
        reset_n = 1'b1;
    endtask : start
    function automatic int at(int k);
        return (k >= 0 && k < mdl.size()) ? mdl[k] : 0;
    endfunction : at
    // Zero-stuffed half-band cascade driven by one impulse, peak at index 8 << stg.
    function automatic void model(int stg);
        int y [$];
        mdl = {};
        for (int n = 0; n < 17; n++) mdl.push_back(n == 8 ? 16384 : 0);
        repeat (stg) begin
            y = {};
            foreach (mdl[n]) begin
                y.push_back(mdl[n]);
                y.push_back((9 * (at(n) + at(n + 1)) - (at(n - 1) + at(n + 2))) >>> 4);
            end
            mdl = y;
        end
    endfunction : model
    function automatic logic near(logic signed [15:0] a, logic signed [15:0] b);
        logic signed [16:0] s;
        s = a + b;
        return s >= -17'sh1 && s <= 17'sh1;
    endfunction : near
    ////////////////////////////////////////////////////////////////////////////////
    task automatic gaps(int want);
        int last;
        int seen;
        last = 0;
        seen = 0;
        repeat (200) begin
            @(posedge mclk);
            #1;
            if (underrun === 1'b1) begin
                if (seen > 1) `CHK("slot gap", want, cycles - last)
                last = cycles;
                seen++;
            end
        end
        `CHK("slots seen", 1, seen > 8)
    endtask : gaps
    task automatic impulse(logic r, int stg);
        int c, hits;
        start(IDUC_CLK_EXT, r, IDUC_MIX_BYP, 32'h0, 1'b0, 1'b1, 32'h40000000);
        hits = 0;
        for (int n = 0; n < 256; n++) begin
            @(posedge mclk);
            #1;
            if (n >= 128) rec[1][n - 128] = outReal;
            else rec[0][n] = outReal;
            if (outReal === 16'sh4000) hits++;
            if (outReal === 16'sh4000) c = n;
        end
        `CHK("peak count", 1, hits)
        model(stg);
        if (hits == 1 && c >= 40 && c < 216)
            for (int n = -40; n <= 40; n++)
                `CHK("impulse", at((8 << stg) + n), rec[(c + n) / 128][(c + n) % 128])
    endtask : impulse
    task automatic osc(iduc_mixmode_e mm, int k);
        int m, full;
        iduc_smp_s v;
        v = $random(seed) & 32'h3FFF3FFF;
        start(IDUC_CLK_EXT, 1'b1, mm, k << 26, 1'b1, 1'b0, v);
        full = 0;
        repeat (250) begin
            @(posedge mclk);
            #1;
            if (inReady === 1'b0) full++;
        end
        for (int n = 0; n < 128; n++) begin
            @(posedge mclk);
            #1;
            rec[0][n] = outReal;
            rec[1][n] = outImag;
        end
        `CHK("buffer filled", 1, full > 0)
        `CHK("outValid", 1'b1, outValid)
        for (m = 0; k != 0 && (m * k) % 64 != 16; m++);
        for (int n = 0; n < 32 && k == 0; n++) begin
            `CHK("real", (int'(v.i) * 32767) >>> 15, rec[0][n])
            if (mm == IDUC_MIX_CPLX) `CHK("imag", (int'(v.q) * 32767) >>> 15, rec[1][n])
        end
        for (int n = 0; n < 32 && k != 0; n++) begin
            `CHK("period", rec[0][n], rec[0][n + 64])
            `CHK("half turn", 1'b1, near(rec[0][n], rec[0][n + 32]))
            if (mm == IDUC_MIX_CPLX) `CHK("quadrature", 1'b1, near(rec[1][n], rec[0][n + m]))
        end
    endtask : osc
    initial begin
        repeat (3) @(posedge mclk);
        #1;
        reset_n = 1'b1;
        for (int c = 0; c < 6; c++) begin
            start(cms[c % 3], c < 3, IDUC_MIX_BYP, 32'h0, 1'b0, 1'b0, 32'h0);
            gaps(c < 3 ? 16 : 8);
        end
        impulse(1'b1, 4);
        impulse(1'b0, 3);
        osc(IDUC_MIX_REAL, ($random(seed) & 31) * 2 + 1);
        osc(IDUC_MIX_CPLX, ($random(seed) & 31) * 2 + 1);
        osc(IDUC_MIX_CPLX, 0);
        results();
    end
endmodule : testbench
bind iduc_top iduc_checker u_chk (.mclk(mclk), .reset_n(reset_n), .clkMode(clkMode),
    .ratio16(ratio16), .mixMode(mixMode), .refClk(refClk), .inValid(inValid),
    .inReady(inReady), .outImag(outImag), .outValid(outValid), .underrun(underrun));
